// ---- coproc_pkg.sv ----
/*
  Shared constants, instruction field layout and operand-count decode
  for the coprocessor multiply, negate and transpose group. Assumes both
  ends run on one clock and see the same 32-bit instruction word.
*/
package coproc_pkg;

  // instruction fields
  localparam int SRC1_LSB = 25;
  localparam int SRC2_LSB = 21;
  localparam int DST_LSB  = 16;
  localparam int MODE_LSB = 12;
  localparam int OP_LSB   = 9;
  localparam int TYPE_BIT = 8;
  localparam int SIZE_BIT = 7;

  // transfer modes and operations
  localparam logic [3:0] MODE_EXEC    = 4'h1;
  localparam logic [3:0] MODE_HOSTREG = 4'h5;
  localparam logic [3:0] MODE_MEM     = 4'h9;
  localparam logic [2:0] OP_MUL       = 3'h0;
  localparam logic [2:0] OP_TRAN      = 3'h1;
  localparam logic [2:0] OP_NEG       = 3'h7;

  // geometry and pointer step in bit addresses
  localparam int          FILE_DEPTH = 16;
  localparam int          MAT_A_LEN  = 10;
  localparam logic [31:0] PTR_STEP   = 32'h0000_0020;
  localparam logic [31:0] PTR_RESET  = 32'h0000_0000;

  // host-side way of getting operands
  typedef enum logic [1:0] {
    XFER_NONE    = 2'b00,
    XFER_HOSTREG = 2'b01,
    XFER_POSTINC = 2'b10,
    XFER_PREDEC  = 2'b11
  } xfer_t;

  // double when both type and size are set
  function automatic logic is_double(input logic [31:0] instr);
    return instr[TYPE_BIT] & instr[SIZE_BIT];
  endfunction

  // operand words carried by the instruction, zero for execute-only
  function automatic logic [2:0] op_words(input logic [31:0] instr);
    logic [2:0] per;
    per = is_double(instr) ? 3'h2 : 3'h1;
    if (instr[MODE_LSB +: 4] == MODE_EXEC)
      return 3'h0;
    if (instr[OP_LSB +: 3] == OP_MUL)
      return 3'(per << 1);
    if (instr[OP_LSB +: 3] == OP_NEG)
      return per;
    return 3'h0;
  endfunction

endpackage

// ---- coproc_if.sv ----
/*
  Link between the host issuing end and the coprocessor end: an
  instruction handshake and an operand-word handshake. Assumes both ends
  share clk; the testbench owns clock and reset.
*/
`timescale 1ns/1ps
interface coproc_if;
  logic        instr_valid;
  logic        instr_ready;
  logic [31:0] instr;
  logic        data_valid;
  logic        data_ready;
  logic [31:0] data;
  logic        busy;

  modport host   (output instr_valid, instr, data_valid, data,
                  input  instr_ready, data_ready, busy);
  modport device (input  instr_valid, instr, data_valid, data,
                  output instr_ready, data_ready, busy);
endinterface

// ---- coproc_device.sv ----
/*
  Coprocessor end: decodes instructions, takes operand words into the
  source registers, then multiplies, negates or transposes in the file_a
  and file_b register files. Assumes the host keeps the pointer and
  operand order rules; link signals come from logic on the same clock.
*/
`timescale 1ns/1ps
module coproc_device (
  input  wire logic        clk,
  input  wire logic        arst_n,
  coproc_if.device         link,
  input  wire logic [4:0]  rd_sel,
  output logic      [63:0] rd_data,
  output logic      [63:0] last_result,
  output logic             exec_done
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOAD = 2'b01,
    S_EXEC = 2'b10
  } state_t;

  state_t      state;
  logic [31:0] cur;
  logic [2:0]  cnt;
  logic [2:0]  words;
  logic [63:0] file_a [coproc_pkg::FILE_DEPTH];
  logic [63:0] file_b [coproc_pkg::FILE_DEPTH];

  // decoded fields of the held instruction
  logic       dbl;
  logic [3:0] src1;
  logic [3:0] src2;
  logic [4:0] dst;
  logic [2:0] op;
  assign dbl  = coproc_pkg::is_double(cur);
  assign src1 = cur[coproc_pkg::SRC1_LSB +: 4];
  assign src2 = cur[coproc_pkg::SRC2_LSB +: 4];
  assign dst  = cur[coproc_pkg::DST_LSB +: 5];
  assign op   = cur[coproc_pkg::OP_LSB +: 3];

  // simplified float multiply: truncating, flushes tiny results to zero
  function automatic logic [63:0] fp_mul(input logic [63:0] a,
                                         input logic [63:0] b,
                                         input logic        d);
    logic [105:0] p;
    logic [63:0]  r;
    int           e;
    r = 64'h0;
    if (d)
    begin
      p = 106'({1'b1, a[51:0]}) * 106'({1'b1, b[51:0]});
      e = int'(a[62:52]) + int'(b[62:52]) - 1023 + int'(p[105]);
      r[63] = a[63] ^ b[63];
      if (a[62:52] == 11'h0 || b[62:52] == 11'h0 || e <= 0)
        r[62:0] = 63'h0;
      else if (e >= 2047)
        r[62:0] = {11'h7FF, 52'h0};
      else
        r[62:0] = {11'(e), p[105] ? p[104:53] : p[103:52]};
    end
    else
    begin
      p = 106'({1'b1, a[22:0]}) * 106'({1'b1, b[22:0]});
      e = int'(a[30:23]) + int'(b[30:23]) - 127 + int'(p[47]);
      r[31] = a[31] ^ b[31];
      if (a[30:23] == 8'h0 || b[30:23] == 8'h0 || e <= 0)
        r[30:0] = 31'h0;
      else if (e >= 255)
        r[30:0] = {8'hFF, 23'h0};
      else
        r[30:0] = {8'(e), p[47] ? p[46:24] : p[45:23]};
    end
    return r;
  endfunction

  // operands and result of the current operation
  logic [63:0] opa;
  logic [63:0] opb;
  logic [63:0] result;
  assign opa = file_a[src1];  // negate source always in file_a
  assign opb = file_b[src2];  // second factor from file_b

  always_comb
  begin
    result = 64'h0;
    if (op == coproc_pkg::OP_MUL)
    begin
      if (!cur[coproc_pkg::TYPE_BIT])
        result = {32'h0, 32'(opa[31:0] * opb[31:0])};
      else
        result = fp_mul(opa, opb, dbl);
    end
    else if (op == coproc_pkg::OP_NEG)
    begin
      if (!cur[coproc_pkg::TYPE_BIT])
        result = {32'h0, ~opa[31:0] + 32'h1};
      else if (dbl)
        result = {~opa[63], opa[62:0]};
      else
        result = {32'h0, ~opa[31], opa[30:0]};
    end
  end

  // where the incoming operand word lands
  logic        ld_b;
  logic        ld_hi;
  logic [2:0]  per;
  assign per   = dbl ? 3'h2 : 3'h1;
  // first word(s) to source one, following ones to source two
  assign ld_b  = (op == coproc_pkg::OP_MUL) && (cnt >= per);
  assign ld_hi = dbl && !cnt[0];         // double: high word first

  // handshake outputs
  assign link.instr_ready = (state == S_IDLE);
  assign link.data_ready  = (state == S_LOAD);
  assign link.busy        = (state != S_IDLE);

  // sequencing: decode, fixed-count operand load, execute
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= S_IDLE;
      cur   <= 32'h0;
      cnt   <= 3'h0;
      words <= 3'h0;
    end
    else
    begin
      case (state)
        S_IDLE:
          if (link.instr_valid)
          begin
            cur   <= link.instr;
            cnt   <= 3'h0;
            words <= coproc_pkg::op_words(link.instr);
            if (coproc_pkg::op_words(link.instr) == 3'h0)
              state <= S_EXEC;
            else
              state <= S_LOAD;
          end
        S_LOAD:
          if (link.data_valid)
          begin
            cnt <= cnt + 3'h1;
            if (cnt == words - 3'h1)
              state <= S_EXEC;
          end
        S_EXEC:
          state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // register files: operand loads, results and transpose
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < coproc_pkg::FILE_DEPTH; i++)
      begin
        file_a[i] <= 64'h0;
        file_b[i] <= 64'h0;
      end
    end
    else if (state == S_LOAD && link.data_valid)
    begin
      // host words go into the named source register
      if (ld_b)
      begin
        if (ld_hi)
          file_b[src2] <= {link.data, file_b[src2][31:0]};
        else if (dbl)
          file_b[src2] <= {file_b[src2][63:32], link.data};
        else
          file_b[src2] <= {32'h0, link.data};
      end
      else
      begin
        if (ld_hi)
          file_a[src1] <= {link.data, file_a[src1][31:0]};
        else if (dbl)
          file_a[src1] <= {file_a[src1][63:32], link.data};
        else
          file_a[src1] <= {32'h0, link.data};
      end
    end
    else if (state == S_EXEC)
    begin
      if (op == coproc_pkg::OP_TRAN)
      begin
        // element 4r+c takes old element 4c+r, in place
        for (int k = 0; k < coproc_pkg::MAT_A_LEN; k++)
          file_a[k] <= tr_elem(k);
        for (int k = 0; k < 16 - coproc_pkg::MAT_A_LEN; k++)
          file_b[k] <= tr_elem(k + coproc_pkg::MAT_A_LEN);
      end
      else if (op == coproc_pkg::OP_MUL || op == coproc_pkg::OP_NEG)
      begin
        if (dst[4])
          file_b[dst[3:0]] <= result;
        else
          file_a[dst[3:0]] <= result;
      end
    end
  end

  // old value feeding transposed slot k
  function automatic logic [63:0] tr_elem(input int k);
    int s;
    s = (k % 4) * 4 + (k / 4);
    if (s < coproc_pkg::MAT_A_LEN)
      return file_a[s];
    return file_b[s - coproc_pkg::MAT_A_LEN];
  endfunction

  // completion pulse and last written result
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exec_done   <= 1'b0;
      last_result <= 64'h0;
    end
    else
    begin
      exec_done <= (state == S_EXEC);
      if (state == S_EXEC && op != coproc_pkg::OP_TRAN)
        last_result <= result;
    end
  end

  // register file readout, bit 4 selects file_b
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data <= 64'h0;
    else if (rd_sel[4])
      rd_data <= file_b[rd_sel[3:0]];
    else
      rd_data <= file_a[rd_sel[3:0]];
  end

endmodule

// ---- coproc_host.sv ----
/*
  Host end: issues one instruction, then supplies its operand words from
  host registers or from memory with postincrement or predecrement of a
  bit-address pointer. Assumes a simple request/acknowledge memory port.
*/
`timescale 1ns/1ps
module coproc_host (
  input  wire logic               clk,
  input  wire logic               arst_n,
  coproc_if.host                  link,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire logic [31:0]        cmd_instr,
  input  wire coproc_pkg::xfer_t  cmd_xfer,
  input  wire logic [31:0]        cmd_ptr,
  input  wire logic [31:0]        cmd_word1,
  input  wire logic [31:0]        cmd_word2,
  output logic                    mem_req,
  output logic      [31:0]        mem_addr,
  input  wire logic [31:0]        mem_rdata,
  input  wire logic               mem_ack,
  output logic                    done
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_INSTR = 3'b001,
    H_DEC   = 3'b010,
    H_FETCH = 3'b011,
    H_SEND  = 3'b100,
    H_DONE  = 3'b101
  } state_t;

  state_t            state;
  coproc_pkg::xfer_t xfer;
  logic [31:0]       word2;
  logic [2:0]        words;
  logic [2:0]        cnt;

  // handshake outputs
  assign cmd_ready        = (state == H_IDLE);
  assign link.instr_valid = (state == H_INSTR);
  assign link.data_valid  = (state == H_SEND);
  assign mem_req          = (state == H_FETCH);

  // next step once a word has been taken
  function automatic state_t after_word(input coproc_pkg::xfer_t x);
    if (x == coproc_pkg::XFER_PREDEC)
      return H_DEC;
    if (x == coproc_pkg::XFER_POSTINC)
      return H_FETCH;
    return H_SEND;
  endfunction

  // issue sequence and operand supply
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state      <= H_IDLE;
      xfer       <= coproc_pkg::XFER_NONE;
      link.instr <= 32'h0;
      link.data  <= 32'h0;
      word2      <= 32'h0;
      words      <= 3'h0;
      cnt        <= 3'h0;
      mem_addr   <= coproc_pkg::PTR_RESET;
      done       <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        H_IDLE:
          if (cmd_valid)
          begin
            link.instr <= cmd_instr;
            xfer       <= cmd_xfer;
            mem_addr   <= cmd_ptr;
            link.data  <= cmd_word1;     // first host register
            word2      <= cmd_word2;
            cnt        <= 3'h0;
            if (cmd_xfer == coproc_pkg::XFER_NONE)
              words <= 3'h0;
            else
              words <= coproc_pkg::op_words(cmd_instr);
            state <= H_INSTR;
          end
        H_INSTR:
          if (link.instr_ready)
          begin
            if (words == 3'h0)
              state <= H_DONE;
            else if (xfer == coproc_pkg::XFER_HOSTREG)
              state <= H_SEND;
            else
              state <= after_word(xfer);
          end
        H_DEC:
        begin
          mem_addr <= mem_addr - coproc_pkg::PTR_STEP;
          state    <= H_FETCH;
        end
        H_FETCH:
          if (mem_ack)
          begin
            link.data <= mem_rdata;
            if (xfer == coproc_pkg::XFER_POSTINC)
              mem_addr <= mem_addr + coproc_pkg::PTR_STEP;
            state <= H_SEND;
          end
        H_SEND:
          if (link.data_ready)
          begin
            cnt <= cnt + 3'h1;
            if (cnt == words - 3'h1)
              state <= H_DONE;
            else
            begin
              if (xfer == coproc_pkg::XFER_HOSTREG)
                link.data <= word2;      // second host register
              state <= after_word(xfer);
            end
          end
        H_DONE:
          if (!link.busy)
          begin
            done  <= 1'b1;
            state <= H_IDLE;
          end
        default:
          state <= H_IDLE;
      endcase
    end
  end

endmodule

// ---- coproc_props.sv ----
/*
  Checker for the instruction and operand handshakes of coproc_if.
  Assumes tb instantiates it beside the interface, one clock domain.
*/
`timescale 1ns/1ps
module coproc_props (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [31:0] instr,
  input wire logic        data_valid,
  input wire logic        data_ready,
  input wire logic [31:0] data,
  input wire logic        busy
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic       take;
  logic [2:0] want;
  logic [2:0] got;
  logic [2:0] next_want;
  logic       feeds;
  logic       dword;
  logic [2:0] opc;

  assign take = instr_valid && instr_ready;

  // decoded fields of the offered instruction
  assign feeds = instr[coproc_pkg::MODE_LSB +: 4] != coproc_pkg::MODE_EXEC;
  assign dword = instr[coproc_pkg::TYPE_BIT] & instr[coproc_pkg::SIZE_BIT];
  assign opc   = instr[coproc_pkg::OP_LSB +: 3];

  // operand words the offered instruction should carry
  always_comb
  begin
    next_want = 3'h0;
    if (feeds && opc == coproc_pkg::OP_MUL)
      next_want = dword ? 3'h4 : 3'h2;
    if (feeds && opc == coproc_pkg::OP_NEG)
      next_want = dword ? 3'h2 : 3'h1;
  end

  // words expected and words taken for the current instruction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      want <= 3'h0;
      got  <= 3'h0;
    end
    else if (take)
    begin
      want <= next_want;
      got  <= 3'h0;
    end
    else if (data_valid && data_ready)
      got <= got + 3'h1;
  end

  ready_idle_a: assert property (instr_ready == !busy)
    else $error("instr_ready is not the inverse of busy");
  instr_hold_a: assert property (instr_valid && !instr_ready |=>
    instr_valid && $stable(instr)) else $error("waiting instruction moved");
  take_busy_a: assert property (take |=> busy && !instr_ready)
    else $error("taken instruction did not make the device busy");
  exec_only_a: assert property (take && next_want == 3'h0 |=>
    busy && !data_ready ##1 !busy) else $error("execute-only too long");
  load_start_a: assert property (take && next_want != 3'h0 |=>
    data_ready) else $error("operand load did not start");
  word_count_a: assert property ($fell(data_ready) |->
    got == want) else $error("operand word count wrong");
  data_hold_a: assert property (data_valid && !data_ready |=>
    data_valid && $stable(data)) else $error("waiting operand moved");
  ready_busy_a: assert property (data_ready |-> busy)
    else $error("operand ready while idle");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("device busy too long");
  reset_idle_a: assert property ($rose(arst_n) |->
    instr_ready && !busy && !data_ready) else $error("not idle at reset");
endmodule

// ---- tb.sv ----
/*
  Testbench: host end and coprocessor end joined by coproc_if, memory
  answered by the bench. Assumes one 40 MHz clock and async reset.
*/
`timescale 1ns/1ps
module tb;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              cmd_ready;
  logic [31:0]       cmd_instr = 32'h0;
  coproc_pkg::xfer_t cmd_xfer = coproc_pkg::XFER_NONE;
  logic [31:0]       cmd_ptr = 32'h0;
  logic [31:0]       cmd_word1 = 32'h0;
  logic [31:0]       cmd_word2 = 32'h0;
  logic              mem_req;
  logic [31:0]       mem_addr;
  logic [31:0]       mem_rdata = 32'h0;
  logic              mem_ack = 1'b0;
  logic              done;
  logic [4:0]        rd_sel = 5'h0;
  logic [63:0]       rd_data;
  logic [63:0]       last_result;
  logic              exec_done;
  logic [31:0]       fetched[$];
  int                err_total = 0;
  int                comparisons = 0;
  int                exec_seen = 0;

  coproc_if link_bus ();

  coproc_host u_coproc_host (
    .clk       (clk),
    .arst_n    (arst_n),
    .link      (link_bus),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_instr (cmd_instr),
    .cmd_xfer  (cmd_xfer),
    .cmd_ptr   (cmd_ptr),
    .cmd_word1 (cmd_word1),
    .cmd_word2 (cmd_word2),
    .mem_req   (mem_req),
    .mem_addr  (mem_addr),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack),
    .done      (done)
  );

  coproc_device u_coproc_device (
    .clk         (clk),
    .arst_n      (arst_n),
    .link        (link_bus),
    .rd_sel      (rd_sel),
    .rd_data     (rd_data),
    .last_result (last_result),
    .exec_done   (exec_done)
  );

  coproc_props u_coproc_props (
    .clk         (clk),
    .arst_n      (arst_n),
    .instr_valid (link_bus.instr_valid),
    .instr_ready (link_bus.instr_ready),
    .instr       (link_bus.instr),
    .data_valid  (link_bus.data_valid),
    .data_ready  (link_bus.data_ready),
    .data        (link_bus.data),
    .busy        (link_bus.busy)
  );

  // 25 ns clock
  always #12.5 clk = ~clk;

  // exec_done pulses, compared once per command
  always @(posedge clk)
    if (exec_done === 1'b1)
      exec_seen++;

  function automatic logic [31:0] mval(input logic [31:0] a);
    return a ^ 32'h5A5A_0000;
  endfunction

  function automatic logic [31:0] ins(input logic [3:0] s1,
    input logic [3:0] s2, input logic [4:0] d, input logic [3:0] m,
    input logic [2:0] op, input logic [1:0] ts);
    return {3'h0, s1, s2, d, m, op, ts, 7'h0};
  endfunction

  // matrix element k to register select
  function automatic logic [4:0] slot(input int k);
    return (k < 10) ? 5'(k) : 5'(k + 6);
  endfunction

  // memory acks at once, released data bus shows the inverse
  always @(posedge clk)
  begin
    if (mem_req && mem_ack)
      fetched.push_back(mem_addr);
    #2;
    mem_ack = mem_req;
    mem_rdata = mem_req ? mval(mem_addr) : ~mem_rdata;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout();
    err_total++;
    end_sim();
  endtask

  // one host command, held until taken, then wait for done
  task automatic run(input logic [31:0] i, input coproc_pkg::xfer_t x,
    input logic [31:0] p, input logic [31:0] w1, input logic [31:0] w2);
    int n;
    int base;
    n = 0;
    base = exec_seen;
    fetched.delete();
    @(posedge clk);
    #2;
    cmd_valid = 1'b1;
    cmd_instr = i;
    cmd_xfer = x;
    cmd_ptr = p;
    cmd_word1 = w1;
    cmd_word2 = w2;
    @(posedge clk);
    while (cmd_ready !== 1'b1)
    begin
      n++;
      if (n > 50)
        timeout();
      @(posedge clk);
    end
    #2;
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 100)
        timeout();
    end
    check("exec_done", 64'(exec_seen - base), 64'h1);
  endtask

  task automatic rd(input logic [4:0] sel, input logic [63:0] exp,
    input string what);
    @(posedge clk);
    #2;
    rd_sel = sel;
    @(posedge clk);
    #1;
    check(what, rd_data, exp);
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #2;
    arst_n = 1'b1;
    run(ins(4'h2, 4'h3, 5'h04, 4'h9, 3'h0, 2'b00),
      coproc_pkg::XFER_PREDEC, 32'h0000_1000, 32'h0, 32'h0);
    check("mul_fetch1", fetched[0], 32'h0000_0FE0);
    check("mul_ptr", mem_addr, 32'h0000_0FC0);
    rd(5'h02, {32'h0, mval(32'h0FE0)}, "mul_src1");
    rd(5'h13, {32'h0, mval(32'h0FC0)}, "mul_src2");
    rd(5'h04, {32'h0, mval(32'h0FE0) * mval(32'h0FC0)}, "mul");
    $display("test multiply integer done");
    run(ins(4'h1, 4'h1, 5'h05, 4'h9, 3'h0, 2'b11),
      coproc_pkg::XFER_PREDEC, 32'h0000_2000, 32'h0, 32'h0);
    check("muld_words", 64'(fetched.size()), 64'h4);
    check("muld_ptr", mem_addr, 32'h0000_1F80);
    rd(5'h01, {mval(32'h1FE0), mval(32'h1FC0)}, "muld_src1");
    rd(5'h11, {mval(32'h1FA0), mval(32'h1F80)}, "muld_src2");
    run(ins(4'h3, 4'h4, 5'h06, 4'h5, 3'h0, 2'b10),
      coproc_pkg::XFER_HOSTREG, 32'h0, 32'h4000_0000, 32'h4040_0000);
    check("mulf", last_result, 64'h40C0_0000);
    rd(5'h14, 64'h4040_0000, "mulf_src2");
    $display("test multiply double done");
    run(ins(4'h5, 4'h0, 5'h17, 4'h5, 3'h7, 2'b00),
      coproc_pkg::XFER_HOSTREG, 32'h0, 32'h0000_0005, 32'h0);
    check("neg_int", last_result, 64'hFFFF_FFFB);
    rd(5'h05, 64'h5, "neg_src");
    run(ins(4'h6, 4'h0, 5'h18, 4'h5, 3'h7, 2'b11),
      coproc_pkg::XFER_HOSTREG, 32'h0, 32'h3FF0_0000, 32'h1234_5678);
    rd(5'h18, 64'hBFF0_0000_1234_5678, "negd");
    run(ins(4'h7, 4'h0, 5'h19, 4'h5, 3'h7, 2'b10),
      coproc_pkg::XFER_HOSTREG, 32'h0, 32'h4000_0000, 32'h0);
    check("negf", last_result, 64'hC000_0000);
    $display("test negate host registers done");
    run(ins(4'h8, 4'h0, 5'h1A, 4'h9, 3'h7, 2'b10),
      coproc_pkg::XFER_POSTINC, 32'h0000_3000, 32'h0, 32'h0);
    check("post_fetch", fetched[0], 32'h0000_3000);
    check("post_ptr", mem_addr, 32'h0000_3020);
    check("post_neg", last_result,
      {32'h0, mval(32'h3000) ^ 32'h8000_0000});
    run(ins(4'h9, 4'h0, 5'h1B, 4'h9, 3'h7, 2'b11),
      coproc_pkg::XFER_PREDEC, 32'h0000_4000, 32'h0, 32'h0);
    check("pre_ptr", mem_addr, 32'h0000_3FC0);
    check("pre_neg", last_result, {mval(32'h3FE0) ^ 32'h8000_0000,
      mval(32'h3FC0)});
    run(ins(4'h5, 4'h0, 5'h1C, 4'h1, 3'h7, 2'b00),
      coproc_pkg::XFER_NONE, 32'h0, 32'h0, 32'h0);
    check("neg_exec", last_result, 64'hFFFF_FFFB);
    $display("test negate memory done");
    for (int k = 15; k >= 0; k--)
      run(ins(4'h0, 4'h0, slot(k), 4'h5, 3'h7, 2'b00),
        coproc_pkg::XFER_HOSTREG, 32'h0, -(32'h100 + k), 32'h0);
    run(ins(4'h0, 4'h0, 5'h00, 4'h1, 3'h1, 2'b00),
      coproc_pkg::XFER_NONE, 32'h0, 32'h0, 32'h0);
    for (int k = 0; k < 16; k++)
      rd(slot(k), 64'(32'h100 + 4 * (k % 4) + k / 4), "tran");
    $display("test transpose done");
    end_sim();
  end
endmodule
